/* design/sfb_pkg.sv */
package sfb_pkg;
   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_LP_READ   = 8'h01;
   localparam logic [7:0] OP_PAGE_READ = 8'hd2;
   localparam logic [7:0] OP_B1_RD_HI  = 8'hd4;
   localparam logic [7:0] OP_B1_RD_LO  = 8'hd1;
   localparam logic [7:0] OP_B2_RD_HI  = 8'hd6;
   localparam logic [7:0] OP_B2_RD_LO  = 8'hd3;
   localparam logic [7:0] OP_B1_WR     = 8'h84;
   localparam logic [7:0] OP_B2_WR     = 8'h87;
   localparam logic [7:0] OP_B1_PROG   = 8'h83;
   localparam logic [7:0] OP_B2_PROG   = 8'h86;

   // ----------------------------------------------------------------
   // Geometry, counts and reset values
   // ----------------------------------------------------------------
   localparam int unsigned PAGE_LONG   = 264;
   localparam int unsigned PAGES       = 2048;
   localparam int unsigned ARRAY_BYTES = PAGES * PAGE_LONG;
   localparam logic [8:0]  OFF_LAST_LONG  = 9'h107;
   localparam logic [8:0]  OFF_LAST_SHORT = 9'h0ff;
   localparam logic [19:0] PAGE_STRIDE = 20'h00108;
   localparam logic [3:0]  HDR_PLAIN      = 4'h4;
   localparam logic [3:0]  HDR_ONE_DUMMY  = 4'h5;
   localparam logic [3:0]  HDR_FOUR_DUMMY = 4'h8;
   localparam logic [3:0]  ADDR_LAST      = 4'h3;
   localparam logic [2:0]  BIT_LAST    = 3'h7;
   localparam logic [7:0]  ERASED      = 8'hff;
   localparam logic [7:0]  DUMMY_BYTE  = 8'h00;
   localparam int unsigned CLK_MHZ       = 200;
   localparam int unsigned SCK_PERIOD_NS = 40;
   localparam int unsigned SCK_HALF = SCK_PERIOD_NS * CLK_MHZ / 2000;
   localparam int unsigned CS_GAP   = 4;

   // Header length in bytes: opcode, address and dummies
   function automatic logic [3:0] hdr_bytes(input logic [7:0] op);
      unique case (op)
         OP_PAGE_READ:             return HDR_FOUR_DUMMY;
         OP_B1_RD_HI, OP_B2_RD_HI: return HDR_ONE_DUMMY;
         default:                  return HDR_PLAIN;
      endcase
   endfunction

   function automatic logic is_array(input logic [7:0] op);
      return (op == OP_LP_READ) || (op == OP_PAGE_READ);
   endfunction

   function automatic logic is_buf_rd(input logic [7:0] op);
      return (op == OP_B1_RD_HI) || (op == OP_B1_RD_LO) ||
             (op == OP_B2_RD_HI) || (op == OP_B2_RD_LO);
   endfunction

   function automatic logic is_buf_wr(input logic [7:0] op);
      return (op == OP_B1_WR) || (op == OP_B2_WR);
   endfunction

   function automatic logic is_prog(input logic [7:0] op);
      return (op == OP_B1_PROG) || (op == OP_B2_PROG);
   endfunction

   function automatic logic is_buf2(input logic [7:0] op);
      return (op == OP_B2_RD_HI) || (op == OP_B2_RD_LO) ||
             (op == OP_B2_WR) || (op == OP_B2_PROG);
   endfunction

   // Three address bytes for a command, per page-size mode
   function automatic logic [23:0] form_addr(input logic [7:0]  op,
                                             input logic [10:0] page,
                                             input logic [8:0]  off,
                                             input logic        short);
      if (is_array(op))
         return short ? {5'h00, page, off[7:0]} : {4'h0, page, off};
      else if (is_prog(op))
         return short ? {5'h00, page, 8'h00} : {4'h0, page, 9'h000};
      else
         return short ? {16'h0000, off[7:0]} : {15'h0000, off};
   endfunction
endpackage

/* design/sfb_link_if.sv */
`timescale 1ns/1ps
// Serial link between host and flash device
interface sfb_link_if;
   logic cs_n;    // Frame select, low active
   logic sck;     // Serial clock from host
   logic si;      // Host to device data
   logic so;      // Device to host data
   logic so_oe;   // Device drives so while high

   modport dev  (input cs_n, input sck, input si, output so, output so_oe);
   modport host (output cs_n, output sck, output si, input so, input so_oe);
endinterface

/* design/sfb_host.sv */
`timescale 1ns/1ps
module sfb_host (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        page_short,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [7:0]  req_op,
   input  wire logic [10:0] req_page,
   input  wire logic [8:0]  req_off,
   input  wire logic [15:0] req_len,
   input  wire logic [7:0]  wr_data,
   output logic             wr_take,
   output logic [7:0]       rd_data,
   output logic             rd_valid,
   sfb_link_if.host         link
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_RUN  = 2'b01,
      H_GAP  = 2'b10
   } sfb_hst_t;

   sfb_hst_t    st_q;
   logic [7:0]  op_q;
   logic [23:0] addr_q;
   logic [3:0]  hdr_q;
   logic [16:0] idx_q;
   logic [16:0] total_q;
   logic [7:0]  sh_q;
   logic [6:0]  in_q;
   logic [2:0]  bit_q;
   logic [3:0]  div_q;
   logic        ph_q;
   logic        sck_q;
   logic        cs_q;
   logic        mosi_q;
   logic [2:0]  so_s_q;
   logic        so_v_q;
   logic        tick;
   logic        fall;
   logic        byte_end;
   logic        last_byte;
   logic [16:0] nidx;
   logic [7:0]  nbyte;

   // ---------------------------------------------------------------
   // Timing and next byte
   // ---------------------------------------------------------------
   assign tick      = (st_q == H_RUN) &&
                      (div_q == 4'(sfb_pkg::SCK_HALF - 1));
   assign fall      = tick && ph_q;
   assign byte_end  = fall && (bit_q == sfb_pkg::BIT_LAST);
   assign nidx      = idx_q + 17'h00001;
   assign last_byte = (nidx == total_q);

   // Next byte: address, then dummies, then data
   always_comb begin
      nbyte = sfb_pkg::DUMMY_BYTE;
      if (nidx == 17'h00001)
         nbyte = addr_q[23:16];
      else if (nidx == 17'h00002)
         nbyte = addr_q[15:8];
      else if (nidx == 17'h00003)
         nbyte = addr_q[7:0];
      else if (nidx >= {13'h0000, hdr_q} && sfb_pkg::is_buf_wr(op_q))
         nbyte = wr_data;
   end

   // Three-flop input filter on the returned data
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         so_s_q <= 3'h0;
         so_v_q <= 1'b0;
      end else begin
         so_s_q <= {so_s_q[1:0], link.so};
         if (so_s_q[1] == so_s_q[2])
            so_v_q <= so_s_q[2];
      end
   end

   // ---------------------------------------------------------------
   // Frame sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q    <= H_IDLE;
         div_q   <= 4'h0;
         total_q <= 17'h00000;
      end else begin
         unique case (st_q)
            H_IDLE: begin
               div_q <= 4'h0;
               if (req_valid) begin
                  st_q    <= H_RUN;
                  total_q <= {13'h0000, sfb_pkg::hdr_bytes(req_op)} +
                             {1'b0, req_len};
               end
            end
            H_RUN: begin
               div_q <= tick ? 4'h0 : div_q + 4'h1;
               if (byte_end && last_byte)
                  st_q <= H_GAP;
            end
            H_GAP: begin
               div_q <= div_q + 4'h1;
               if (div_q == 4'(sfb_pkg::CS_GAP - 1))
                  st_q <= H_IDLE;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   // Chip select held low over the whole frame
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs_q      <= 1'b1;
         req_ready <= 1'b0;
      end else begin
         req_ready <= (st_q == H_IDLE) && !req_valid;
         if (st_q == H_IDLE && req_valid)
            cs_q <= 1'b0;
         else if (byte_end && last_byte)
            cs_q <= 1'b1;
      end
   end

   // Clock phases, shift out and sample on fall
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         op_q    <= 8'h00;
         addr_q  <= 24'h000000;
         hdr_q   <= 4'h0;
         idx_q   <= 17'h00000;
         sh_q    <= 8'h00;
         in_q    <= 7'h00;
         bit_q   <= 3'h0;
         ph_q    <= 1'b0;
         sck_q   <= 1'b0;
         mosi_q  <= 1'b0;
         wr_take <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
      end else begin
         wr_take  <= 1'b0;
         rd_valid <= 1'b0;
         if (st_q == H_IDLE && req_valid) begin
            op_q   <= req_op;
            // Address layout per command and mode
            addr_q <= sfb_pkg::form_addr(req_op, req_page, req_off,
                                         page_short);
            hdr_q  <= sfb_pkg::hdr_bytes(req_op);
            idx_q  <= 17'h00000;
            sh_q   <= {req_op[6:0], 1'b0};
            mosi_q <= req_op[7];
            bit_q  <= 3'h0;
            ph_q   <= 1'b0;
         end else if (tick && !ph_q) begin
            sck_q <= 1'b1;
            ph_q  <= 1'b1;
         end else if (fall) begin
            sck_q <= 1'b0;
            ph_q  <= 1'b0;
            bit_q <= bit_q + 3'h1;
            in_q  <= {in_q[5:0], so_v_q};
            if (byte_end) begin
               idx_q  <= nidx;
               sh_q   <= {nbyte[6:0], 1'b0};
               mosi_q <= last_byte ? 1'b0 : nbyte[7];
               wr_take <= !last_byte && sfb_pkg::is_buf_wr(op_q) &&
                          (nidx >= {13'h0000, hdr_q});
               if (!sfb_pkg::is_buf_wr(op_q) && !sfb_pkg::is_prog(op_q) &&
                   idx_q >= {13'h0000, hdr_q}) begin
                  rd_data  <= {in_q, so_v_q};
                  rd_valid <= 1'b1;
               end
            end else begin
               sh_q   <= {sh_q[6:0], 1'b0};
               mosi_q <= sh_q[7];
            end
         end
      end
   end

   assign link.cs_n = cs_q;
   assign link.sck  = sck_q;
   assign link.si   = mosi_q;
endmodule

/* design/sfb_dev.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Overview of operation
// - Low-power read: 01h, three address bytes
// - Long pages: 11-bit page, 9-bit offset
// - Short pages: 19-bit linear, 11-bit page
// - Continuous read crosses pages, wraps array end
// - Select high ends read, output released
// - Array reads leave both buffers untouched
// - Host keeps select low through frame
// - Page read: D2h, address, four dummies
// - Page read wraps within same page
// - D4h/D1h buffer one, D6h/D3h buffer two
// - Buffer read address carries buffer offset
// - Fast buffer reads need one dummy byte
// - Buffer read wraps to buffer start
// - Buffer write 84h/87h with starting offset
// - Short mode write: eight-bit offset
// - Write data fills buffer, wraps, until select
// - Program with erase: 83h/86h, page index
// - Short mode program address layout
// - Select rise: erase page, then program
// - Busy shown during erase and program
// - Erase or program failure sets error
// ------------------------------------------------------------------
module sfb_dev (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic page_short,
   output logic      busy,
   output logic      erase_program_error_flag,
   sfb_link_if.dev   link
);
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ERASE = 2'b01,
      ST_PROG  = 2'b10,
      ST_CHECK = 2'b11
   } sfb_dst_t;

   logic [7:0]  flash_mem [0:sfb_pkg::ARRAY_BYTES-1];
   logic [7:0]  buf_a     [0:sfb_pkg::PAGE_LONG-1];
   logic [7:0]  buf_b     [0:sfb_pkg::PAGE_LONG-1];

   logic        link_rst_n;
   logic [2:0]  bit_q;
   logic [3:0]  byte_q;
   logic [6:0]  sr_q;
   logic [7:0]  op_q;
   logic [23:0] addr_q;
   logic        data_q;
   logic [10:0] pg_q;
   logic [8:0]  off_q;
   logic [7:0]  tx_q;
   logic        so_q;
   logic        oe_q;
   logic        arm_q;
   logic [10:0] arm_pg_q;
   logic        arm_b2_q;
   logic [7:0]  byte_in;
   logic [23:0] addr_full;
   logic        start_now;
   logic        data_end;
   logic [10:0] st_pg;
   logic [10:0] cur_pg;
   logic [8:0]  cur_off;
   logic [8:0]  off_last;
   logic [8:0]  nxt_off;
   logic [10:0] nxt_pg;
   logic [7:0]  rd_src;

   logic [2:0]  mode_s_q;
   logic        short_q;
   logic [2:0]  cs_s_q;
   logic        cs_hi_q;
   logic [2:0]  arm_s_q;
   sfb_dst_t    st_q;
   sfb_dst_t    st_d;
   logic [8:0]  cnt_q;
   logic [10:0] ppg_q;
   logic        pb2_q;
   logic        cnt_end;
   logic [19:0] pidx;
   logic [7:0]  pbuf;

   // ---------------------------------------------------------------
   // Link-side decode
   // ---------------------------------------------------------------
   // Frame logic is cleared whenever select is high
   assign link_rst_n = nrst & ~link.cs_n;
   assign byte_in    = {sr_q, link.si};
   assign addr_full  = (byte_q == sfb_pkg::ADDR_LAST) ?
                       {addr_q[15:0], byte_in} : addr_q;
   assign start_now  = !data_q && (bit_q == sfb_pkg::BIT_LAST) &&
                       (byte_q != 4'h0) &&
                       (byte_q + 4'h1 == sfb_pkg::hdr_bytes(op_q));
   assign data_end   = data_q && (bit_q == sfb_pkg::BIT_LAST);
   // Page index position set by the page-size mode
   assign st_pg      = short_q ? addr_full[18:8] : addr_full[19:9];
   assign cur_pg     = start_now ? st_pg : pg_q;
   // Offset: low 8 or 9 bits for array and buffer
   assign cur_off    = start_now ?
                       (short_q ? {1'b0, addr_full[7:0]} : addr_full[8:0])
                       : off_q;
   assign off_last   = short_q ? sfb_pkg::OFF_LAST_SHORT
                               : sfb_pkg::OFF_LAST_LONG;
   // Offset wraps at page or buffer end
   assign nxt_off    = (cur_off == off_last) ? 9'h000 : cur_off + 9'h001;
   // Only the low-power read moves on to the next page
   assign nxt_pg     = ((cur_off == off_last) &&
                        (op_q == sfb_pkg::OP_LP_READ)) ?
                       cur_pg + 11'h001 : cur_pg;

   // Byte source: array or one buffer, never both
   always_comb begin
      rd_src = sfb_pkg::DUMMY_BYTE;
      if (sfb_pkg::is_array(op_q))
         rd_src = flash_mem[20'(cur_pg) * sfb_pkg::PAGE_STRIDE +
                            20'(cur_off)];
      else if (sfb_pkg::is_buf2(op_q))
         rd_src = buf_b[cur_off];
      else
         rd_src = buf_a[cur_off];
   end

   // Bit counter and input shifter, sampled on rising edge
   always_ff @(posedge link.sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         bit_q <= 3'h0;
         sr_q  <= 7'h00;
      end else begin
         bit_q <= bit_q + 3'h1;
         sr_q  <= byte_in[6:0];
      end
   end

   // Opcode, address and header length
   always_ff @(posedge link.sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         byte_q <= 4'h0;
         op_q   <= 8'h00;
         addr_q <= 24'h000000;
         data_q <= 1'b0;
      end else if (bit_q == sfb_pkg::BIT_LAST && !data_q) begin
         byte_q <= byte_q + 4'h1;
         if (byte_q == 4'h0)
            op_q <= byte_in;
         else if (byte_q <= sfb_pkg::ADDR_LAST)
            addr_q <= {addr_q[15:0], byte_in};
         if (start_now)
            data_q <= 1'b1;
      end
   end

   // Pointer and next output byte
   always_ff @(posedge link.sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         pg_q  <= 11'h000;
         off_q <= 9'h000;
         tx_q  <= 8'h00;
      end else if (start_now && sfb_pkg::is_buf_wr(op_q)) begin
         off_q <= cur_off;
      end else if (start_now || data_end) begin
         tx_q  <= rd_src;
         pg_q  <= nxt_pg;
         off_q <= nxt_off;
      end
   end

   // Write data into the chosen buffer until select rises
   always_ff @(posedge link.sck) begin
      if (data_end && sfb_pkg::is_buf_wr(op_q)) begin
         if (sfb_pkg::is_buf2(op_q))
            buf_b[off_q] <= byte_in;
         else
            buf_a[off_q] <= byte_in;
      end
   end

   // Program request, armed once the page address is in
   always_ff @(posedge link.sck or negedge nrst) begin
      if (!nrst) begin
         arm_q    <= 1'b0;
         arm_pg_q <= 11'h000;
         arm_b2_q <= 1'b0;
      end else if (start_now && sfb_pkg::is_prog(op_q)) begin
         arm_q    <= 1'b1;
         arm_pg_q <= st_pg;
         arm_b2_q <= sfb_pkg::is_buf2(op_q);
      end else if (byte_q == 4'h0 && bit_q == 3'h0) begin
         arm_q <= 1'b0;
      end
   end

   // Output changes on falling edge, released by select
   always_ff @(negedge link.sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         so_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (data_q && (sfb_pkg::is_array(op_q) ||
                              sfb_pkg::is_buf_rd(op_q))) begin
         so_q <= tx_q[~bit_q];
         oe_q <= 1'b1;
      end
   end

   assign link.so    = so_q;
   assign link.so_oe = oe_q;

   // ---------------------------------------------------------------
   // Self-timed erase and program
   // ---------------------------------------------------------------
   // Crossings: mode, select and arm each by three flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_s_q <= 3'h0;
         short_q  <= 1'b0;
         cs_s_q   <= 3'h7;
         cs_hi_q  <= 1'b1;
         arm_s_q  <= 3'h0;
      end else begin
         mode_s_q <= {mode_s_q[1:0], page_short};
         cs_s_q   <= {cs_s_q[1:0], link.cs_n};
         arm_s_q  <= {arm_s_q[1:0], arm_q};
         if (mode_s_q[1] == mode_s_q[2])
            short_q <= mode_s_q[2];
         if (cs_s_q[1] == cs_s_q[2])
            cs_hi_q <= cs_s_q[2];
      end
   end

   assign cnt_end = (cnt_q == off_last);
   assign pidx    = 20'(ppg_q) * sfb_pkg::PAGE_STRIDE + 20'(cnt_q);
   assign pbuf    = pb2_q ? buf_b[cnt_q] : buf_a[cnt_q];

   // Erase the page, then copy the buffer, then verify
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE:  if (!cs_hi_q && cs_s_q[1] && cs_s_q[2] &&
                       arm_s_q[1] && arm_s_q[2])
                      st_d = ST_ERASE;
         ST_ERASE: if (cnt_end) st_d = ST_PROG;
         ST_PROG:  if (cnt_end) st_d = ST_CHECK;
         ST_CHECK: if (cnt_end) st_d = ST_IDLE;
      endcase
   end

   // State, busy flag and byte counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q  <= ST_IDLE;
         busy  <= 1'b0;
         cnt_q <= 9'h000;
         ppg_q <= 11'h000;
         pb2_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         busy  <= (st_d != ST_IDLE);
         cnt_q <= (st_d != st_q || cnt_end) ? 9'h000 : cnt_q + 9'h001;
         if (st_q == ST_IDLE && st_d == ST_ERASE) begin
            ppg_q <= arm_pg_q;
            pb2_q <= arm_b2_q;
         end
      end
   end

   // Error flag: cleared at start, set on any bad byte
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         erase_program_error_flag <= 1'b0;
      else if (st_q == ST_PROG && flash_mem[pidx] != sfb_pkg::ERASED)
         erase_program_error_flag <= 1'b1;
      else if (st_q == ST_CHECK && flash_mem[pidx] != pbuf)
         erase_program_error_flag <= 1'b1;
      else if (st_q == ST_IDLE && st_d == ST_ERASE)
         erase_program_error_flag <= 1'b0;
   end

   // Array writes, erased state all ones
   always_ff @(posedge clk) begin
      if (st_q == ST_ERASE)
         flash_mem[pidx] <= sfb_pkg::ERASED;
      else if (st_q == ST_PROG)
         flash_mem[pidx] <= pbuf;
   end
endmodule

/* sim/sfb_link_properties.sv */
`timescale 1ns/1ps
module sfb_link_properties (
   input wire logic clk,
   input wire logic nrst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe
);
   logic [9:0] bits_q;
   logic [7:0] op_q;
   logic [9:0] hdr_bits;

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // --------------------------------------------------------------
   // Frame bit count and captured opcode
   // --------------------------------------------------------------
   // Counts sck rises in the frame, wraps on purpose
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bits_q <= 10'h000;
      end else if (cs_n) begin
         bits_q <= 10'h000;
      end else if ($rose(sck)) begin
         bits_q <= bits_q + 10'h001;
      end
   end

   // First eight bits are the opcode, MSB first
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         op_q <= 8'h00;
      end else if ($rose(sck) && bits_q < 10'h008) begin
         op_q <= {op_q[6:0], si};
      end
   end

   // Header length of each read command, all ones for the rest
   assign hdr_bits = (op_q == sfb_pkg::OP_PAGE_READ) ? 10'h040 :
                     (op_q == sfb_pkg::OP_B1_RD_HI ||
                      op_q == sfb_pkg::OP_B2_RD_HI) ? 10'h028 :
                     (op_q == sfb_pkg::OP_LP_READ ||
                      op_q == sfb_pkg::OP_B1_RD_LO ||
                      op_q == sfb_pkg::OP_B2_RD_LO) ? 10'h020 : 10'h3ff;

   // --------------------------------------------------------------
   // Link timing sequences and checks
   // --------------------------------------------------------------
   sequence high_half;
      sck [*4] ##1 !sck;
   endsequence

   sequence low_lead;
      !sck [*4] ##1 sck;
   endsequence

   a_release_select: assert property ($rose(cs_n) |-> !so_oe ##1 !so_oe)
      else $error("so not released after frame end");
   a_idle_clock: assert property (cs_n |-> !sck)
      else $error("sck active outside frame");
   a_si_steady: assert property (sck && $past(sck) |-> $stable(si))
      else $error("si moved while sck high");
   a_so_on_fall: assert property ($changed(so) && so_oe |-> $fell(sck))
      else $error("so changed away from falling sck");
   a_whole_bytes: assert property ($rose(cs_n) |-> bits_q[2:0] == 3'h0)
      else $error("frame ended off a byte boundary");
   a_first_rise: assert property ($fell(cs_n) |-> low_lead)
      else $error("first sck rise not four cycles after select");
   a_high_phase: assert property ($rose(sck) |-> high_half)
      else $error("sck high phase not four cycles");
   a_out_after_hdr: assert property ($rose(so_oe) |-> bits_q == hdr_bits)
      else $error("output began at wrong header length");
   a_oe_on_fall: assert property ($rose(so_oe) |-> $fell(sck) && !cs_n)
      else $error("output enable away from falling sck");
endmodule

/* sim/serial_flash_read_buffer_commands_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
   failures++; $display("ERROR %s expected %h seen %h", nm, e, s); end end
module serial_flash_read_buffer_commands_tb;
   logic        clk = 0, nrst = 0, page_short = 0, req_valid = 0, saw;
   logic [7:0]  req_op = 0, wr_data = 0, rd_data;
   logic [10:0] req_page = 0, p0;
   logic [8:0]  req_off = 0;
   logic [15:0] req_len = 0;
   logic        req_ready, wr_take, rd_valid, busy, err;
   logic [7:0]  wq[$], rq[$], mb[2][264], pg[2][264];
   logic [7:0]  rops[4] = '{sfb_pkg::OP_B1_RD_HI, sfb_pkg::OP_B1_RD_LO,
                            sfb_pkg::OP_B2_RD_HI, sfb_pkg::OP_B2_RD_LO};
   int          failures = 0, n_compared = 0, wi, L, k, m, b, i;

   sfb_link_if link_bus ();
   sfb_host i_sfb_host (.clk(clk), .nrst(nrst), .page_short(page_short),
      .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
      .req_page(req_page), .req_off(req_off), .req_len(req_len),
      .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
      .rd_valid(rd_valid), .link(link_bus.host));
   sfb_dev i_sfb_dev (.clk(clk), .nrst(nrst), .page_short(page_short),
      .busy(busy), .erase_program_error_flag(err), .link(link_bus.dev));
   sfb_link_properties i_props (.clk(clk), .nrst(nrst),
      .cs_n(link_bus.cs_n), .sck(link_bus.sck), .si(link_bus.si),
      .so(link_bus.so), .so_oe(link_bus.so_oe));

   // Clock, write data feed and read capture
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (wr_take && wi + 1 < wq.size()) begin
         wi++;
         wr_data <= wq[wi];
      end
      if (rd_valid) rq.push_back(rd_data);
   end

   task automatic complete_run();
      if (failures == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // One whole frame through the host, bounded waits
   task automatic xfer(input logic [7:0] op, input logic [8:0] off,
                       input int len, input logic [10:0] pg_i);
      wi = 0;
      wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
      rq.delete();
      @(posedge clk);
      req_valid <= 1'b1;
      req_op    <= op;
      req_page  <= pg_i;
      req_off   <= off;
      req_len   <= 16'(len);
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      for (k = 0; k < 40000 && !(req_ready && link_bus.cs_n); k++) begin
         @(posedge clk);
         #1;
      end
      if (k == 40000) begin
         failures++;
         complete_run();
      end
   endtask

   // Expected byte: 0/1 page read, 2 continuous, 3/4 buffers
   function automatic logic [7:0] exp_byte(input int src, input int i);
      int a;
      a = L - 4 + i;
      if (src == 2) return (a < L) ? pg[0][a] : pg[1][a - L];
      if (src < 2) return pg[src][a % L];
      return mb[src - 3][a % L];
   endfunction

   task automatic chk_rd(input int src);
      `CHK("read count", 8, rq.size())
      for (int j = 0; j < 8; j++) `CHK("read byte", exp_byte(src, j), rq[j])
   endtask

   // Main sequence: both page sizes, corner offsets near page end
   initial begin
      void'($urandom(88324));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      for (m = 0; m < 2; m++) begin
         page_short <= m[0];
         L = m ? 256 : 264;
         p0 = m ? 11'($urandom) : 11'h7ff;
         repeat (8) @(posedge clk);
         for (b = 0; b < 2; b++) begin
            wq.delete();
            for (i = 0; i < 16; i++) begin
               wq.push_back(8'($urandom));
               mb[b][(L - 8 + i) % L] = wq[i];
            end
            xfer(b ? sfb_pkg::OP_B2_WR : sfb_pkg::OP_B1_WR, 9'(L - 8), 16, 0);
         end
         wq.delete();
         for (b = 0; b < 2; b++) begin
            xfer(b ? sfb_pkg::OP_B2_PROG : sfb_pkg::OP_B1_PROG, 0, 0, p0 + 11'(b));
            saw = 1'b0;
            for (k = 0; k < 2000 && !(saw && !busy); k++) begin
               @(posedge clk);
               #1;
               saw |= busy;
            end
            `CHK("busy cycle", 2'b10, {saw, busy})
            `CHK("error flag", 1'b0, err)
            if (k == 2000)
               complete_run();
            pg[b] = mb[b];
         end
         xfer(sfb_pkg::OP_PAGE_READ, 9'(L - 4), 8, p0);
         chk_rd(0);
         xfer(sfb_pkg::OP_LP_READ, 9'(L - 4), 8, p0);
         chk_rd(2);
         for (i = 0; i < 4; i++) begin
            xfer(rops[i], 9'(L - 4), 8, p0);
            chk_rd(3 + i / 2);
         end
      end
      complete_run();
   end
endmodule
